// >>> npic_core.sv
// nested priority interrupt controller with wishbone register slave
//
// Contract
// (R01) four nesting levels, higher level preempts lower
// (R02) sixteen vectors at FFE0h..FFFFh by hardware order
// (R03) current level in condition code bits 5, 3
// (R04) finish current instruction before service entry
// (R05) entry pushes PC, X, A, condition code
// (R06) maskable entry loads level from vector priority
// (R07) then PC loads vector address, fetch handler
// (R08) return restores saved registers and level
// (R09) level codes: 10, 01, 00, 11 disables
// (R10) highest software priority wins, hardware breaks ties
// (R11) unserviced requests stay latched as pending
// (R12) reset and trap ignore level, rank highest
// (R13) non-maskable: stack except reset, level 3
// (R14) reset and trap leave Halt
// (R15) trap instruction raises non-maskable trap request
// (R16) after reset, run at level 3
// (R17) maskable served only if enabled and above level
// (R18) edge requests latched, auto-cleared, sense selectable
// (R19) shared-line pin triggers are ORed
// (R20) peripheral request is flag AND enable
// (R21) clearing sequence drops the request latch
// (R22) wait ends on any, halt only capable sources
// (R23) priority writes selecting level 0 are ignored
`timescale 1ns/1ps
`include "npic_regs.svh"
module npic_core
  import npic_pkg::*;
#(
  parameter int NUM_SRC = 14,
  parameter int NUM_EXT = 4,
  parameter int PINS_PER_LINE = 4,
  parameter logic [13:0] HALT_CAPABLE = 14'h013F
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [7:0] wb_dat_i,
  output logic [7:0] wb_dat_o,
  output logic wb_ack_o,
  // request sources
  input wire logic [NUM_EXT*PINS_PER_LINE-1:0] ext_pin_i,
  input wire logic [NUM_EXT*PINS_PER_LINE-1:0] ext_pin_sel_i,
  input wire logic [NUM_SRC-NUM_EXT-1:0] per_flag_i,
  input wire logic [NUM_SRC-NUM_EXT-1:0] per_en_i,
  input wire logic [NUM_SRC-NUM_EXT-1:0] per_clear_i,
  // core handshake
  input wire logic instr_end_i,
  input wire logic trap_i,
  input wire logic return_from_interrupt_i,
  input wire logic wait_i,
  input wire logic halt_i,
  input wire logic [15:0] cur_pc_i,
  input wire logic [7:0] x_i,
  input wire logic [7:0] a_i,
  input wire logic pop_valid_i,
  input wire logic [7:0] pop_data_i,
  output logic stack_push_o,
  output logic [7:0] stack_data_o,
  output logic stack_pop_o,
  output logic pc_load_o,
  output logic [15:0] pc_value_o,
  output logic busy_o,
  output logic sleeping_o,
  output logic [7:0] condition_code_reg_o,
  output logic [3:0] serving_o
);
  localparam int NPER = NUM_SRC - NUM_EXT;

  // priority code to rank: larger rank is more urgent
  function automatic logic [1:0] rank(input logic [1:0] code);
    unique case (code)
      `NPIC_LVL0: rank = 2'd0; // (R09)
      `NPIC_LVL1: rank = 2'd1;
      `NPIC_LVL2: rank = 2'd2;
      default: rank = 2'd3;
    endcase
  endfunction

  logic [7:0] prio_ff [4];
  logic [7:0] sense_ff;
  logic [NUM_SRC-1:0] en_ff;
  logic [NUM_SRC-1:0] pend_ff;
  logic [7:0] cc_ff;
  logic trap_ff;
  npic_state_type state_ff;
  npic_sleep_type sleep_ff;
  logic [2:0] cnt_ff;
  logic [3:0] win_ff;
  logic win_nmi_ff;
  logic [NUM_EXT*PINS_PER_LINE-1:0] pin_s1_ff, pin_s2_ff, pin_d_ff;
  logic after_halt_ff;
  logic [7:0] wb_dat_ff;
  logic wb_ack_ff;
  logic stack_push_ff, stack_pop_ff, pc_load_ff;
  logic [7:0] stack_data_ff;
  logic [15:0] pc_value_ff;
  logic [15:0] saved_pc_ff;

  // bus decode
  logic wb_req, wb_wr;
  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_ff;
  assign wb_wr = wb_req && wb_we_i;

  // two-stage synchroniser on the pins, then an edge detect on stage two
  always_ff @(posedge clk_i) begin
    pin_s1_ff <= ext_pin_i;
    pin_s2_ff <= pin_s1_ff;
    pin_d_ff <= pin_s2_ff;
  end

  // per-line trigger: sense bits per line, 0 falling 1 rising
  logic [NUM_EXT-1:0] ext_trig;
  always_comb begin
    logic hit;
    hit = 1'b0;
    for (int l = 0; l < NUM_EXT; l++) begin
      hit = 1'b0;
      for (int p = 0; p < PINS_PER_LINE; p++) begin
        if (ext_pin_sel_i[l*PINS_PER_LINE+p]) begin
          hit = hit | (sense_ff[l]
            ? (pin_s2_ff[l*PINS_PER_LINE+p] & !pin_d_ff[l*PINS_PER_LINE+p])
            : (!pin_s2_ff[l*PINS_PER_LINE+p] & pin_d_ff[l*PINS_PER_LINE+p]));
        end
      end
      ext_trig[l] = hit; // (R19) (R18)
    end
  end

  // raw request vector: lines first, peripherals after
  logic [NUM_SRC-1:0] raw_req;
  assign raw_req = {per_flag_i & per_en_i, ext_trig}; // (R20)

  function automatic logic [1:0] vprio(input int i);
    vprio = prio_ff[i/4][(i%4)*2 +: 2];
  endfunction

  // arbitration: software level first, lowest index (hardware) breaks ties
  logic [1:0] cur_rank;
  logic found;
  logic [3:0] sel_idx;
  logic [1:0] sel_rank, win_prio;
  logic halt_mode;
  assign halt_mode = sleep_ff == NPIC_SLEEP_HALT || after_halt_ff;
  assign cur_rank =
    rank({cc_ff[`NPIC_CC_LVLH], cc_ff[`NPIC_CC_LVLL]}); // (R03)
  assign win_prio = vprio(int'(win_ff));
  always_comb begin
    logic [1:0] r;
    r = 2'd0;
    found = 1'b0;
    sel_idx = 4'h0;
    sel_rank = 2'd0;
    for (int i = 0; i < NUM_SRC; i++) begin
      r = rank(vprio(i));
      if (pend_ff[i] && en_ff[i] && r > cur_rank // (R17) (R01)
          && (!halt_mode || HALT_CAPABLE[i]) // (R22)
          && (!found || r > sel_rank)) begin // (R10)
        found = 1'b1;
        sel_idx = 4'(i);
        sel_rank = r;
      end
    end
  end

  // software priority registers; level 0 code is refused per field
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int k = 0; k < 4; k++) prio_ff[k] <= `NPIC_PRIO_RST;
    end else if (wb_wr && wb_adr_i <= `NPIC_ADR_PRIO3) begin
      for (int f = 0; f < 4; f++) begin
        if (wb_dat_i[f*2 +: 2] != `NPIC_LVL0) begin // (R23)
          prio_ff[wb_adr_i[1:0]][f*2 +: 2] <= wb_dat_i[f*2 +: 2];
        end
      end
      if (wb_adr_i == `NPIC_ADR_PRIO3) begin
        prio_ff[3][7:4] <= 4'hF; // top fields are fixed
      end
    end
  end

  // sense and enable controls
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sense_ff <= `NPIC_SENSE_RST;
      en_ff <= '0;
    end else if (wb_wr) begin
      if (wb_adr_i == `NPIC_ADR_SENSE) sense_ff <= wb_dat_i; // (R18)
      if (wb_adr_i == `NPIC_ADR_SRCEN) en_ff <= {6'h3F, wb_dat_i};
    end
  end

  // pending latches: set beats clear in the same cycle
  logic take_mask, at_bound;
  assign at_bound = state_ff == NPIC_RUN && instr_end_i
    && sleep_ff == NPIC_SLEEP_NONE; // a sleeping core takes no entry
  assign take_mask = at_bound && !trap_ff && found;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pend_ff <= '0;
    end else begin
      for (int i = 0; i < NUM_SRC; i++) begin
        if (raw_req[i]) begin
          pend_ff[i] <= 1'b1; // (R11)
        end else if (i >= NUM_EXT && per_clear_i[i-NUM_EXT]) begin
          pend_ff[i] <= 1'b0; // (R21)
        end else if (i < NUM_EXT && take_mask && sel_idx == 4'(i)) begin
          pend_ff[i] <= 1'b0; // (R18)
        end else if (wb_wr && wb_adr_i == `NPIC_ADR_PENDCLR
                     && i < 8 && wb_dat_i[i % 8]) begin
          pend_ff[i] <= 1'b0;
        end else if (i >= NUM_EXT && !per_flag_i[i-NUM_EXT]) begin
          pend_ff[i] <= 1'b0; // (R20)
        end
      end
    end
  end

  // trap request raised by the trap instruction
  always_ff @(posedge clk_i) begin
    if (rst_i) trap_ff <= 1'b0;
    else if (trap_i) trap_ff <= 1'b1; // (R15)
    else if (at_bound) trap_ff <= 1'b0;
  end

  // sleep tracking; wake on any request from wait, capable only from halt
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sleep_ff <= NPIC_SLEEP_NONE; // (R14)
      after_halt_ff <= 1'b0;
    end else if (trap_i) begin
      sleep_ff <= NPIC_SLEEP_NONE; // (R14)
      after_halt_ff <= 1'b0;
    end else if (sleep_ff == NPIC_SLEEP_WAIT && |(pend_ff & en_ff)) begin
      sleep_ff <= NPIC_SLEEP_NONE; // (R22)
    end else if (sleep_ff == NPIC_SLEEP_HALT && found) begin
      sleep_ff <= NPIC_SLEEP_NONE; // (R22)
      after_halt_ff <= 1'b1;
    end else if (halt_i) begin
      sleep_ff <= NPIC_SLEEP_HALT;
    end else if (wait_i) begin
      sleep_ff <= NPIC_SLEEP_WAIT;
    end else if (take_mask) begin
      after_halt_ff <= 1'b0; // later entries see all sources again
    end
  end

  // entry and return sequencer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_ff <= NPIC_VECT; // reset vector fetched without stacking
      win_nmi_ff <= 1'b1;
      win_ff <= 4'hF;
      cnt_ff <= 3'h0;
      saved_pc_ff <= 16'h0000;
    end else begin
      unique case (state_ff)
        NPIC_RUN: begin
          cnt_ff <= 3'h0;
          saved_pc_ff <= cur_pc_i;
          if (instr_end_i && sleep_ff == NPIC_SLEEP_NONE) begin // (R04)
            if (trap_ff) begin
              state_ff <= NPIC_STACK; // (R12) (R13)
              win_nmi_ff <= 1'b1;
              win_ff <= 4'hE;
            end else if (found) begin
              state_ff <= NPIC_STACK;
              win_nmi_ff <= 1'b0;
              win_ff <= sel_idx;
            end else if (return_from_interrupt_i) begin
              state_ff <= NPIC_UNSTACK; // (R08)
            end
          end
        end
        NPIC_STACK: begin
          cnt_ff <= cnt_ff + 3'h1; // (R05)
          if (cnt_ff == `NPIC_STACK_BYTES - 3'h1) state_ff <= NPIC_VECT;
        end
        NPIC_VECT: state_ff <= NPIC_RUN; // (R07)
        NPIC_UNSTACK: begin
          if (pop_valid_i) begin
            cnt_ff <= cnt_ff + 3'h1;
            if (cnt_ff == `NPIC_STACK_BYTES - 3'h1) state_ff <= NPIC_RESUME;
          end
        end
        default: state_ff <= NPIC_RUN;
      endcase
    end
  end

  // stack byte order: PCL, PCH, X, A, CC (popped in reverse)
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stack_push_ff <= 1'b0;
      stack_data_ff <= 8'h00;
    end else begin
      stack_push_ff <= state_ff == NPIC_STACK; // (R05)
      unique case (cnt_ff)
        3'h0: stack_data_ff <= saved_pc_ff[7:0];
        3'h1: stack_data_ff <= saved_pc_ff[15:8];
        3'h2: stack_data_ff <= x_i;
        3'h3: stack_data_ff <= a_i;
        default: stack_data_ff <= cc_ff;
      endcase
    end
  end

  // vector address: reset FFFE, trap FFFC, vector n at FFFA - 2n
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pc_load_ff <= 1'b0;
      pc_value_ff <= 16'h0000;
      stack_pop_ff <= 1'b0;
    end else begin
      stack_pop_ff <= state_ff == NPIC_UNSTACK && !pop_valid_i;
      pc_load_ff <= state_ff == NPIC_VECT || state_ff == NPIC_RESUME;
      if (state_ff == NPIC_VECT) begin
        if (!win_nmi_ff)
          pc_value_ff <= `NPIC_VEC_TOP - {11'h0, win_ff, 1'b0};
        else if (win_ff == 4'hF) pc_value_ff <= `NPIC_VEC_RESET;
        else pc_value_ff <= `NPIC_VEC_TRAP; // (R02) (R07)
      end else if (state_ff == NPIC_UNSTACK && pop_valid_i) begin
        if (cnt_ff == 3'h3) pc_value_ff[15:8] <= pop_data_i; // (R08)
        if (cnt_ff == 3'h4) pc_value_ff[7:0] <= pop_data_i;
      end
    end
  end

  // condition code: level bits driven by entry, return and software
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cc_ff <= `NPIC_CC_RST; // (R16)
    end else if (state_ff == NPIC_VECT) begin
      if (win_nmi_ff) begin
        {cc_ff[`NPIC_CC_LVLH], cc_ff[`NPIC_CC_LVLL]} <= `NPIC_LVL3; // (R13)
      end else begin
        {cc_ff[`NPIC_CC_LVLH], cc_ff[`NPIC_CC_LVLL]} <= win_prio; // (R06)
      end
    end else if (state_ff == NPIC_UNSTACK && pop_valid_i
                 && cnt_ff == 3'h0) begin
      cc_ff <= pop_data_i; // (R08)
    end else if (wb_wr && wb_adr_i == `NPIC_ADR_CCR) begin
      cc_ff <= wb_dat_i;
    end
  end

  // register read mux and single-cycle ack
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_ff <= 1'b0;
      wb_dat_ff <= 8'h00;
    end else begin
      wb_ack_ff <= wb_req;
      if (wb_req && !wb_we_i) begin
        unique case (wb_adr_i)
          `NPIC_ADR_PRIO0: wb_dat_ff <= prio_ff[0];
          `NPIC_ADR_PRIO1: wb_dat_ff <= prio_ff[1];
          `NPIC_ADR_PRIO2: wb_dat_ff <= prio_ff[2];
          `NPIC_ADR_PRIO3: wb_dat_ff <= prio_ff[3];
          `NPIC_ADR_SENSE: wb_dat_ff <= sense_ff;
          `NPIC_ADR_SRCEN: wb_dat_ff <= en_ff[7:0];
          `NPIC_ADR_PEND: wb_dat_ff <= pend_ff[7:0];
          `NPIC_ADR_CCR: wb_dat_ff <= cc_ff;
          `NPIC_ADR_STAT: wb_dat_ff <= {2'h0, pend_ff[13:8]};
          default: wb_dat_ff <= 8'h00;
        endcase
      end
    end
  end

  assign wb_dat_o = wb_dat_ff;
  assign wb_ack_o = wb_ack_ff;
  assign stack_push_o = stack_push_ff;
  assign stack_data_o = stack_data_ff;
  assign stack_pop_o = stack_pop_ff;
  assign pc_load_o = pc_load_ff;
  assign pc_value_o = pc_value_ff;
  assign condition_code_reg_o = cc_ff;
  assign serving_o = win_ff;

  // status outputs registered
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      busy_o <= 1'b1;
      sleeping_o <= 1'b0;
    end else begin
      busy_o <= state_ff != NPIC_RUN;
      sleeping_o <= sleep_ff != NPIC_SLEEP_NONE;
    end
  end
endmodule

// >>> npic_regs.svh
// register offsets, reset values and field positions of the interrupt unit
`ifndef NPIC_REGS_SVH
`define NPIC_REGS_SVH
`define NPIC_ADR_PRIO0 4'h0
`define NPIC_ADR_PRIO1 4'h1
`define NPIC_ADR_PRIO2 4'h2
`define NPIC_ADR_PRIO3 4'h3
`define NPIC_ADR_SENSE 4'h4
`define NPIC_ADR_SRCEN 4'h5
`define NPIC_ADR_PEND 4'h6
`define NPIC_ADR_CCR 4'h7
`define NPIC_ADR_STAT 4'h8
`define NPIC_ADR_PENDCLR 4'h9
`define NPIC_PRIO_RST 8'hFF
`define NPIC_SENSE_RST 8'h00
`define NPIC_SRCEN_RST 8'h00
`define NPIC_CC_RST 8'hEA
`define NPIC_CC_LVLH 5
`define NPIC_CC_LVLL 3
`define NPIC_LVL0 2'h2
`define NPIC_LVL1 2'h1
`define NPIC_LVL2 2'h0
`define NPIC_LVL3 2'h3
`define NPIC_VEC_RESET 16'hFFFE
`define NPIC_VEC_TRAP 16'hFFFC
`define NPIC_VEC_TOP 16'hFFFA
`define NPIC_VEC_BASE 16'hFFE0
`define NPIC_STACK_BYTES 3'h5
`endif

// >>> npic_pkg.sv
// types shared by the nested interrupt unit
package npic_pkg;
  typedef enum logic [2:0] {
    NPIC_RUN, NPIC_STACK, NPIC_VECT, NPIC_UNSTACK, NPIC_RESUME
  } npic_state_type;
  typedef enum logic [1:0] {
    NPIC_SLEEP_NONE, NPIC_SLEEP_WAIT, NPIC_SLEEP_HALT
  } npic_sleep_type;
endpackage

// >>> npic_core_props.sv
// concurrent checks on the ports of the nested interrupt unit
`timescale 1ns/1ps
`include "npic_regs.svh"
module npic_core_props (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // register bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [7:0] wb_dat_o,
  input wire logic wb_ack_o,
  // core side
  input wire logic halt_i,
  input wire logic pop_valid_i,
  input wire logic stack_push_o,
  input wire logic stack_pop_o,
  input wire logic pc_load_o,
  input wire logic [15:0] pc_value_o,
  input wire logic busy_o,
  input wire logic sleeping_o,
  input wire logic [7:0] condition_code_reg_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // stacking is one unbroken burst of five bytes
  sequence s_push5;
    stack_push_o [*5] ##1 !stack_push_o;
  endsequence
  // vector fetch lands in the top vector page on an even address
  sequence s_vec_load;
    ##[0:4] (pc_load_o && pc_value_o >= `NPIC_VEC_BASE && !pc_value_o[0]);
  endsequence
  a_push_five_bytes: assert property ($rose(stack_push_o) |-> s_push5)
    else $error("stacking burst is not five bytes");
  a_push_then_vector: assert property (
    $fell(stack_push_o) |-> s_vec_load)
    else $error("no vector load after stacking");
  a_push_while_busy: assert property (stack_push_o |-> busy_o)
    else $error("stacking while not busy");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_answers: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus request not answered next cycle");
  a_unmapped_zero: assert property (wb_cyc_i && wb_stb_i && !wb_we_i &&
    !wb_ack_o && wb_adr_i > 4'h9 |=> wb_dat_o == 8'h00)
    else $error("unmapped read not zero");
  a_reset_level_three: assert property ($fell(rst_i) |-> busy_o &&
    condition_code_reg_o[5] && condition_code_reg_o[3])
    else $error("reset does not leave level 3");
  a_nonmask_level: assert property (pc_load_o &&
    (pc_value_o == `NPIC_VEC_TRAP || pc_value_o == `NPIC_VEC_RESET) |->
    ##[0:1] (condition_code_reg_o[5] && condition_code_reg_o[3]))
    else $error("non-maskable entry not at level 3");
  a_pop_held: assert property (
    stack_pop_o && !pop_valid_i |=> stack_pop_o)
    else $error("pop request dropped early");
  a_halt_sleeps: assert property (
    halt_i && !busy_o |-> ##[1:3] sleeping_o)
    else $error("halt did not sleep");
endmodule
bind npic_core npic_core_props i_npic_core_props (.clk_i(clk_i),
  .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .halt_i(halt_i), .pop_valid_i(pop_valid_i),
  .stack_push_o(stack_push_o), .stack_pop_o(stack_pop_o),
  .pc_load_o(pc_load_o), .pc_value_o(pc_value_o), .busy_o(busy_o),
  .sleeping_o(sleeping_o), .condition_code_reg_o(condition_code_reg_o));

// >>> npic_cpu_model.sv
// stack memory of the core as seen by the interrupt unit
`timescale 1ns/1ps
module npic_cpu_model (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // stack traffic
  input wire logic stack_push_i,
  input wire logic [7:0] stack_data_i,
  input wire logic stack_pop_i,
  input wire logic slow_i,
  output logic pop_valid_o,
  output logic [7:0] pop_data_o
);
  logic [7:0] mem_ff [0:31];
  logic [4:0] sp_ff;
  logic [1:0] dly_ff;
  // last in first out; slow mode stalls each pop a few cycles
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sp_ff <= 5'h00;
      dly_ff <= 2'h0;
      pop_valid_o <= 1'b0;
      pop_data_o <= 8'hA5;
    end else begin
      pop_valid_o <= 1'b0;
      pop_data_o <= ~pop_data_o; // stale byte never looks valid
      if (stack_push_i) begin
        mem_ff[sp_ff] <= stack_data_i;
        sp_ff <= sp_ff + 5'h01;
      end else if (stack_pop_i && !pop_valid_o) begin
        if (slow_i && dly_ff != 2'h3) begin
          dly_ff <= dly_ff + 2'h1;
        end else begin
          dly_ff <= 2'h0;
          pop_valid_o <= 1'b1;
          pop_data_o <= mem_ff[sp_ff - 5'h01];
          sp_ff <= sp_ff - 5'h01;
        end
      end
    end
  end
endmodule

// >>> npic_core_tb.sv
// self-checking bench for the nested interrupt unit
`timescale 1ns/1ps
module npic_core_tb;
  logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, ie = 0;
  logic trap = 0, rfi = 0, halt = 0, slow = 0, wt = 0;
  logic ack, push, pop, pv, pcl, busy, slp;
  logic [3:0] adr = 4'h0, serv;
  logic [7:0] dat = 8'h00, q, dat_o, cc, sdat, pdat;
  logic [15:0] pins = 16'h0000, sel = 16'h0000, pcv;
  logic [9:0] flag = 10'h000, clr = 10'h000, en = 10'h3FF;
  logic [7:0] exp_stk [0:4] = '{8'h34, 8'h12, 8'h56, 8'h78, 8'hE2};
  int failures = 0, tests_run = 0, ticks = 0;
  always #2 clk_i = ~clk_i;
  npic_core i_npic_core (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(dat),
    .wb_dat_o(dat_o), .wb_ack_o(ack), .ext_pin_i(pins),
    .ext_pin_sel_i(sel), .per_flag_i(flag), .per_en_i(en),
    .per_clear_i(clr), .instr_end_i(ie), .trap_i(trap),
    .return_from_interrupt_i(rfi), .wait_i(wt), .halt_i(halt),
    .cur_pc_i(16'h1234), .x_i(8'h56), .a_i(8'h78), .pop_valid_i(pv),
    .pop_data_i(pdat), .stack_push_o(push), .stack_data_o(sdat),
    .stack_pop_o(pop), .pc_load_o(pcl), .pc_value_o(pcv), .busy_o(busy),
    .sleeping_o(slp), .condition_code_reg_o(cc), .serving_o(serv));
  npic_cpu_model i_npic_cpu_model (.clk_i(clk_i), .rst_i(rst_i),
    .stack_push_i(push), .stack_data_i(sdat), .stack_pop_i(pop),
    .slow_i(slow), .pop_valid_o(pv), .pop_data_o(pdat));
  task chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // one classic cycle, held until ack
  task wb(input logic [3:0] a, input logic w, input logic [7:0] d);
    @(posedge clk_i);
    cyc <= 1; stb <= 1; we <= w; adr <= a; dat <= d;
    do @(posedge clk_i); while (ack !== 1'b1);
    q = dat_o;
    cyc <= 0; stb <= 0; we <= 0;
  endtask
  task rd(input logic [3:0] a, input logic [7:0] e);
    wb(a, 1'b0, 8'h00);
    chk({8'h00, q}, {8'h00, e});
  endtask
  // one instruction boundary, optionally a trap or a return
  task step(input logic t, input logic r);
    @(posedge clk_i);
    ie <= 1; trap <= t; rfi <= r;
    @(posedge clk_i);
    ie <= 0; trap <= 0; rfi <= 0;
  endtask
  task load(input logic [15:0] v, input logic [7:0] c);
    do @(posedge clk_i); while (pcl !== 1'b1);
    chk(pcv, v);
    repeat (2) @(posedge clk_i);
    chk({8'h00, cc}, {8'h00, c});
  endtask
  task flags(input logic [9:0] f, input logic [9:0] c);
    @(posedge clk_i);
    flag <= f; clr <= c;
    @(posedge clk_i);
    clr <= 10'h000;
  endtask
  task t_reset;
    rst_i <= 1;
    repeat (4) @(posedge clk_i);
    rst_i <= 0;
    load(16'hFFFE, 8'hEA);
  endtask
  task t_regs;
    for (int i = 0; i < 4; i++) rd(i[3:0], 8'hFF);
    rd(4'hF, 8'h00);
    rd(4'h7, 8'hEA);
    wb(4'h0, 1'b1, 8'hCF);
    rd(4'h0, 8'hCF);
    wb(4'h0, 1'b1, 8'h64);
    rd(4'h0, 8'h44);
  endtask
  // trap at level 3 still enters, at the boundary after the trap
  task t_trap;
    step(1'b1, 1'b0);
    step(1'b0, 1'b0);
    load(16'hFFFC, 8'hEA);
    step(1'b0, 1'b1);
    load(16'h1234, 8'hEA);
  endtask
  task t_ext;
    wb(4'h4, 1'b1, 8'h01);
    wb(4'h5, 1'b1, 8'h71);
    @(posedge clk_i);
    sel <= 16'h0006;
    @(posedge clk_i);
    pins <= 16'h0004;
    repeat (6) @(posedge clk_i);
    rd(4'h6, 8'h01);
    wb(4'h9, 1'b1, 8'h01);
    rd(4'h6, 8'h00);
  endtask
  task t_nest;
    int n;
    wb(4'h1, 1'b1, 8'hC5);
    wb(4'h7, 1'b1, 8'hE2);
    flags(10'h001, 10'h000);
    step(1'b0, 1'b0);
    load(16'hFFF2, 8'hCA);
    chk({12'h000, serv}, 16'h0004);
    for (int k = 0; k < 5; k++)
      chk({8'h00, i_npic_cpu_model.mem_ff[k]}, {8'h00, exp_stk[k]});
    flags(10'h006, 10'h001);
    step(1'b0, 1'b0);
    load(16'hFFEE, 8'hC2);
    chk({12'h000, serv}, 16'h0006);
    flags(10'h002, 10'h004);
    slow <= 1;
    step(1'b0, 1'b1);
    load(16'h1234, 8'hCA);
    slow <= 0;
    n = 0;
    step(1'b0, 1'b0);
    repeat (12) begin
      @(posedge clk_i);
      if (pcl === 1'b1) n++;
    end
    chk(n[15:0], 16'h0000);
    step(1'b0, 1'b1);
    load(16'h1234, 8'hE2);
    step(1'b0, 1'b0);
    load(16'hFFF0, 8'hCA);
    flags(10'h000, 10'h002);
    step(1'b0, 1'b1);
    load(16'h1234, 8'hE2);
  endtask
  task t_halt;
    // wait sleeps until any enabled request is pending
    @(posedge clk_i);
    wt <= 1;
    @(posedge clk_i);
    wt <= 0;
    repeat (2) @(posedge clk_i);
    chk({15'h0, slp}, 16'h0001);
    flag <= 10'h004;
    repeat (4) @(posedge clk_i);
    chk({15'h0, slp}, 16'h0000);
    @(posedge clk_i);
    halt <= 1;
    @(posedge clk_i);
    halt <= 0;
    flag <= 10'h004;
    repeat (10) @(posedge clk_i);
    chk({15'h0, slp}, 16'h0001);
    step(1'b1, 1'b0);
    step(1'b0, 1'b0);
    load(16'hFFFC, 8'hEA);
    chk({15'h0, slp}, 16'h0000);
    step(1'b0, 1'b1);
    load(16'h1234, 8'hE2);
    step(1'b0, 1'b0);
    load(16'hFFEE, 8'hC2);
  endtask
  task finish_test;
    $display("checks %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // hang guard, far above the few hundred cycles the run needs
  always @(posedge clk_i) begin
    ticks++;
    if (ticks == 8000) begin
      failures++;
      finish_test;
    end
  end
  initial begin
    t_reset;
    t_regs;
    t_trap;
    t_ext;
    t_nest;
    t_halt;
    finish_test;
  end
endmodule
